// >>> pkg/tfr_pkg.sv
`default_nettype none
package tfr_pkg;

    // clock and serial framing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BAUD = 9600;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned STOP_BITS = 1;
    localparam int unsigned FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
    localparam int unsigned CNT_W = 12;
    localparam logic [CNT_W-1:0] BIT_CNT_MAX = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_CNT_MAX = CNT_W'(BIT_CYCLES / 2 - 1);
    localparam logic [3:0] LAST_BIT = 4'(FRAME_BITS - 1);

    // report period
    localparam int unsigned REPORT_MS = 250;
    localparam int unsigned REPORT_CYCLES = (CLK_HZ / 1000) * REPORT_MS;

    // firmware version code, value arbitrary
    localparam logic [7:0] FW_VERSION_DEF = 8'h0C;

    // register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_INFO = 4'h3;

    // register fields and reset values
    localparam int unsigned CTRL_VERBOSE = 0;
    localparam int unsigned EV_W = 5;
    localparam int unsigned EV_RECORD = 0;
    localparam int unsigned EV_BOOT = 1;
    localparam int unsigned EV_REQ = 2;
    localparam int unsigned EV_FERR = 3;
    localparam int unsigned EV_IGNORED = 4;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [EV_W-1:0] MASK_RST = 5'h00;

    // characters
    localparam logic [7:0] CH_Z = 8'h5A;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_REQ = 8'h41;
    localparam logic [7:0] CH_PANEL = 8'h4E;
    localparam logic [7:0] CH_COMP = 8'h43;
    localparam logic [7:0] CH_MANUAL = 8'h4D;
    localparam logic [7:0] CH_SPEED = 8'h53;
    localparam logic [7:0] CH_TORQUE = 8'h54;
    localparam logic [7:0] CH_ROAD = 8'h52;

    // start-up message text, followed by the version number and CR
    localparam int unsigned BOOT_LEN = 10;
    localparam logic [8*BOOT_LEN-1:0] BOOT_TEXT = "POWER ON V";
    localparam logic [3:0] BOOT_LAST = 4'(BOOT_LEN - 1);

    // record fields
    localparam int unsigned VAL_W = 16;
    localparam int unsigned SPEED_W = 14;
    localparam int unsigned LOAD_W = 7;
    localparam int unsigned THR_W = 10;
    localparam int unsigned ADC_W = 10;
    localparam int unsigned ADC_N = 4;
    localparam logic [2:0] TOP_DIGIT = 3'd4;
    localparam logic [2:0] POINT_DIGIT = 3'd3;
    localparam logic [3:0] FLD_SPEED1 = 4'h0;
    localparam logic [3:0] FLD_SPEED2 = 4'h1;
    localparam logic [3:0] FLD_TORQUE = 4'h2;
    localparam logic [3:0] FLD_LOAD = 4'h3;
    localparam logic [3:0] FLD_MODE = 4'h4;
    localparam logic [3:0] FLD_SETPT = 4'h5;
    localparam logic [3:0] FLD_THROTTLE = 4'h6;
    localparam logic [3:0] FLD_ALARM = 4'h7;
    localparam logic [3:0] FLD_ANALOG1 = 4'h8;
    localparam logic [3:0] FLD_ANALOG4 = 4'hB;
    localparam logic [3:0] FLD_FW = 4'hC;

    // mode of control loop
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_SPEED = 2'h1;
    localparam logic [1:0] MODE_TORQUE = 2'h2;
    localparam logic [1:0] MODE_ROAD = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_BOOT = 4'h1,
        ST_LOAD = 4'h2,
        ST_MODE2 = 4'h3,
        ST_DIV = 4'h4,
        ST_DIGNXT = 4'h5,
        ST_NEXTF = 4'h6,
        ST_DONE = 4'h7,
        ST_SEND = 4'h8
    } tfr_state_e;

    function automatic logic [VAL_W-1:0] tfr_pow10(input logic [2:0] idx);
        case (idx)
            3'd0: tfr_pow10 = 16'h0001;
            3'd1: tfr_pow10 = 16'h000A;
            3'd2: tfr_pow10 = 16'h0064;
            3'd3: tfr_pow10 = 16'h03E8;
            default: tfr_pow10 = 16'h2710;
        endcase
    endfunction

endpackage
`default_nettype wire

// >>> rtl/tfr_uart.sv
`timescale 1ns/1ps
`default_nettype none
module tfr_uart import tfr_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // transmit side
    input wire logic i_tx_go,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_busy,
    output logic o_txd,
    // receive side
    input wire logic i_rxd,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_ferr
);

    logic [CNT_W-1:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [9:0] tx_shift;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic rx_busy;
    logic [CNT_W-1:0] rx_cnt;
    logic [3:0] rx_bits;

    wire tx_bit_end = tx_cnt == BIT_CNT_MAX;
    wire rx_start = ~rx_busy & rx_prev & ~rx_s2;

    // start, eight data bits lsb first, one stop, no parity
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_busy <= 1'b0;
            o_txd <= 1'b1;
            tx_cnt <= '0;
            tx_bits <= 4'h0;
            tx_shift <= 10'h3FF;
        end else if (!o_tx_busy) begin
            if (i_tx_go) begin
                o_tx_busy <= 1'b1;
                o_txd <= 1'b0;
                tx_shift <= {1'b1, i_tx_data, 1'b0};
                tx_cnt <= '0;
                tx_bits <= 4'h0;
            end
        end else if (tx_bit_end) begin
            tx_cnt <= '0;
            if (tx_bits == LAST_BIT) begin
                o_tx_busy <= 1'b0;
                o_txd <= 1'b1;
            end else begin
                o_txd <= tx_shift[1];
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_bits <= tx_bits + 4'h1;
            end
        end else begin
            tx_cnt <= tx_cnt + 1'b1;
        end
    end

    // two-flop synchroniser, then edge and mid-bit sampling
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_s1 <= i_rxd;
            rx_s2 <= rx_s1;
            rx_prev <= rx_s2;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_busy <= 1'b0;
            rx_cnt <= '0;
            rx_bits <= 4'h0;
            o_rx_valid <= 1'b0;
            o_rx_data <= 8'h00;
            o_rx_ferr <= 1'b0;
        end else begin
            o_rx_valid <= 1'b0;
            o_rx_ferr <= 1'b0;
            if (rx_start) begin
                rx_busy <= 1'b1;
                rx_cnt <= HALF_CNT_MAX;
                rx_bits <= 4'h0;
            end else if (rx_busy) begin
                if (rx_cnt != '0) begin
                    rx_cnt <= rx_cnt - 1'b1;
                end else begin
                    rx_cnt <= BIT_CNT_MAX;
                    rx_bits <= rx_bits + 4'h1;
                    if (rx_bits == 4'h0) begin
                        rx_busy <= ~rx_s2;
                    end else if (rx_bits == LAST_BIT) begin
                        rx_busy <= 1'b0;
                        o_rx_valid <= rx_s2;
                        o_rx_ferr <= ~rx_s2;
                    end else begin
                        o_rx_data <= {rx_s2, o_rx_data[7:1]};
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> rtl/tfr_framer.sv
//
// Contract
// - The link runs asynchronous at 9600 baud, no parity, one stop bit, both ways.
// - Every character carries eight data bits between start and stop bit.
// - With verbose on, a full record goes out unasked every 250 ms.
// - After power-up a start-up message with the firmware version is sent.
// - With verbose off, a received A makes the block send exactly one record.
// - A record is Z, then speed1, speed2, torque, load, mode, set point, throttle, alarm, four analogs, then CR.
// - Adjacent fields are separated by one space.
// - Mode is two letters: N or C for source, then M, S, T or R for loop type.
// - Throttle is 0 for closed up to 1023 for wide open.
// - Alarm is 0 without alarm and 1 with one.
// - Each analog field is a 10-bit conversion with 5 V full scale.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tfr_framer import tfr_pkg::*; #(
    parameter int unsigned REPORT_PERIOD = REPORT_CYCLES,
    parameter logic [7:0] FW_VERSION = FW_VERSION_DEF
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_irq,
    // serial link
    input wire logic i_rxd,
    output logic o_txd,
    // measurements
    input wire logic [SPEED_W-1:0] i_speed_disp,
    input wire logic [SPEED_W-1:0] i_speed_hidden,
    input wire logic [VAL_W-1:0] i_torque_milli,
    input wire logic [LOAD_W-1:0] i_load_pct,
    input wire logic i_computer_ctl,
    input wire logic [1:0] i_loop_mode,
    input wire logic [SPEED_W-1:0] i_set_point,
    input wire logic [THR_W-1:0] i_throttle,
    input wire logic i_alarm,
    input wire logic [ADC_N*ADC_W-1:0] i_analog
);

    // register state
    logic verbose;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;

    // record engine state
    tfr_state_e state;
    tfr_state_e ret_state;
    logic [3:0] field;
    logic [2:0] pidx;
    logic [VAL_W-1:0] val;
    logic [3:0] dig;
    logic started;
    logic dot_done;
    logic boot_mode;
    logic [3:0] boot_idx;
    logic boot_pend;
    logic report_pend;
    logic [7:0] tx_char;
    logic tx_go;
    logic ev_record;
    logic ev_boot;
    logic [31:0] tick_cnt;
    logic tick;

    // snapshot taken when a record starts
    logic [SPEED_W-1:0] snap_speed1;
    logic [SPEED_W-1:0] snap_speed2;
    logic [VAL_W-1:0] snap_torque;
    logic [LOAD_W-1:0] snap_load;
    logic snap_comp;
    logic [1:0] snap_loop;
    logic [SPEED_W-1:0] snap_setpt;
    logic [THR_W-1:0] snap_thr;
    logic snap_alarm;
    logic [ADC_W-1:0] snap_adc [ADC_N];

    // serial engine
    logic tx_busy;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ferr;

    tfr_uart u_uart (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_tx_go(tx_go),
        .i_tx_data(tx_char),
        .o_tx_busy(tx_busy),
        .o_txd(o_txd),
        .i_rxd(i_rxd),
        .o_rx_valid(rx_valid),
        .o_rx_data(rx_data),
        .o_rx_ferr(rx_ferr)
    );

    // field value selection
    function automatic logic [VAL_W-1:0] pick_value(input logic [3:0] f);
        case (f)
            FLD_SPEED1: pick_value = VAL_W'(snap_speed1);
            FLD_SPEED2: pick_value = VAL_W'(snap_speed2);
            FLD_TORQUE: pick_value = snap_torque;
            FLD_LOAD: pick_value = VAL_W'(snap_load);
            FLD_SETPT: pick_value = VAL_W'(snap_setpt);
            FLD_THROTTLE: pick_value = VAL_W'(snap_thr);
            FLD_ALARM: pick_value = VAL_W'(snap_alarm);
            FLD_FW: pick_value = VAL_W'(FW_VERSION);
            default: pick_value = VAL_W'(snap_adc[2'(f - FLD_ANALOG1)]);
        endcase
    endfunction

    logic [VAL_W-1:0] fld_value;
    always_comb fld_value = pick_value(field);
    wire [VAL_W-1:0] pow_now = tfr_pow10(pidx);
    wire val_ge = val >= pow_now;
    wire is_torque = (field == FLD_TORQUE) && !boot_mode;
    wire [2:0] min_pidx = is_torque ? POINT_DIGIT : 3'd0;
    wire show_digit = (dig != 4'h0) || started || (pidx <= min_pidx);
    wire need_dot = is_torque && (pidx == POINT_DIGIT) && !dot_done;
    wire tx_free = ~tx_busy & ~tx_go;
    wire [7:0] digit_char = CH_ZERO + {4'h0, dig};
    wire [7:0] boot_char = BOOT_TEXT[8*(BOOT_LAST - boot_idx) +: 8];
    wire [7:0] src_char = snap_comp ? CH_COMP : CH_PANEL;
    wire [7:0] loop_char = (snap_loop == MODE_MANUAL) ? CH_MANUAL :
                           (snap_loop == MODE_SPEED) ? CH_SPEED :
                           (snap_loop == MODE_TORQUE) ? CH_TORQUE : CH_ROAD;
    wire last_field = boot_mode || (field == FLD_ANALOG4);

    // host requests and link events
    wire got_req = rx_valid && (rx_data == CH_REQ) && !verbose;
    wire got_ignored = rx_valid && !got_req;

    // register decode
    wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
    wire wr_mask = i_wr && (i_addr == REG_MASK);
    wire rd_status = i_rd && (i_addr == REG_STATUS);
    wire busy = state != ST_IDLE;
    wire [EV_W-1:0] events;
    assign events[EV_RECORD] = ev_record;
    assign events[EV_BOOT] = ev_boot;
    assign events[EV_REQ] = got_req;
    assign events[EV_FERR] = rx_ferr;
    assign events[EV_IGNORED] = got_ignored;
    wire [EV_W-1:0] next_status = (rd_status ? '0 : status) | events;
    wire [7:0] rd_mux = (i_addr == REG_CTRL) ? {7'h00, verbose} :
                        (i_addr == REG_STATUS) ? {3'h0, status} :
                        (i_addr == REG_MASK) ? {3'h0, mask} :
                        (i_addr == REG_INFO) ? {4'h0, busy, boot_pend, report_pend, verbose} :
                        8'h00;

    // registers and interrupt
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            verbose <= CTRL_RST;
            mask <= MASK_RST;
            status <= '0;
            o_rdata <= 8'h00;
            o_irq <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                verbose <= i_wdata[CTRL_VERBOSE];
            end
            if (wr_mask) begin
                mask <= i_wdata[EV_W-1:0];
            end
            status <= next_status;
            o_rdata <= i_rd ? rd_mux : 8'h00;
            o_irq <= |(next_status & mask);
        end
    end

    // verbose period timer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (!verbose) begin
                tick_cnt <= '0;
            end else if (tick_cnt == REPORT_PERIOD - 1) begin
                tick_cnt <= '0;
                tick <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 32'h1;
            end
        end
    end

    // measurement snapshot at record start
    wire start_record = (state == ST_IDLE) && !boot_pend && report_pend;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            snap_speed1 <= '0;
            snap_speed2 <= '0;
            snap_torque <= '0;
            snap_load <= '0;
            snap_comp <= 1'b0;
            snap_loop <= MODE_MANUAL;
            snap_setpt <= '0;
            snap_thr <= '0;
            snap_alarm <= 1'b0;
        end else if (start_record) begin
            snap_speed1 <= i_speed_disp;
            snap_speed2 <= i_speed_hidden;
            snap_torque <= i_torque_milli;
            snap_load <= i_load_pct;
            snap_comp <= i_computer_ctl;
            snap_loop <= i_loop_mode;
            snap_setpt <= i_set_point;
            snap_thr <= i_throttle;
            snap_alarm <= i_alarm;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < ADC_N; gi++) begin : g_adc
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    snap_adc[gi] <= '0;
                end else if (start_record) begin
                    snap_adc[gi] <= i_analog[gi*ADC_W +: ADC_W];
                end
            end
        end
    endgenerate

    // record and message sequencer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            ret_state <= ST_IDLE;
            field <= FLD_SPEED1;
            pidx <= TOP_DIGIT;
            val <= '0;
            dig <= 4'h0;
            started <= 1'b0;
            dot_done <= 1'b0;
            boot_mode <= 1'b0;
            boot_idx <= 4'h0;
            boot_pend <= 1'b1;
            report_pend <= 1'b0;
            tx_char <= 8'h00;
            tx_go <= 1'b0;
            ev_record <= 1'b0;
            ev_boot <= 1'b0;
        end else begin
            tx_go <= 1'b0;
            ev_record <= 1'b0;
            ev_boot <= 1'b0;
            if (tick || got_req) begin
                report_pend <= 1'b1;
            end
            unique case (state)
                ST_IDLE: begin
                    if (boot_pend) begin
                        boot_pend <= 1'b0;
                        boot_mode <= 1'b1;
                        boot_idx <= 4'h0;
                        state <= ST_BOOT;
                    end else if (report_pend) begin
                        if (!(tick || got_req)) begin
                            report_pend <= 1'b0;
                        end
                        boot_mode <= 1'b0;
                        field <= FLD_SPEED1;
                        tx_char <= CH_Z;
                        ret_state <= ST_LOAD;
                        state <= ST_SEND;
                    end
                end
                ST_BOOT: begin
                    tx_char <= boot_char;
                    boot_idx <= boot_idx + 4'h1;
                    field <= FLD_FW;
                    ret_state <= (boot_idx == BOOT_LAST) ? ST_LOAD : ST_BOOT;
                    state <= ST_SEND;
                end
                ST_LOAD: begin
                    if (field == FLD_MODE && !boot_mode) begin
                        tx_char <= src_char;
                        ret_state <= ST_MODE2;
                        state <= ST_SEND;
                    end else begin
                        val <= fld_value;
                        pidx <= TOP_DIGIT;
                        dig <= 4'h0;
                        started <= 1'b0;
                        dot_done <= 1'b0;
                        state <= ST_DIV;
                    end
                end
                ST_MODE2: begin
                    tx_char <= loop_char;
                    ret_state <= ST_NEXTF;
                    state <= ST_SEND;
                end
                ST_DIV: begin
                    if (val_ge) begin
                        val <= val - pow_now;
                        dig <= dig + 4'h1;
                    end else if (show_digit) begin
                        tx_char <= digit_char;
                        started <= 1'b1;
                        ret_state <= ST_DIGNXT;
                        state <= ST_SEND;
                    end else begin
                        state <= ST_DIGNXT;
                    end
                end
                ST_DIGNXT: begin
                    if (need_dot) begin
                        tx_char <= CH_DOT;
                        dot_done <= 1'b1;
                        ret_state <= ST_DIGNXT;
                        state <= ST_SEND;
                    end else if (pidx == 3'd0) begin
                        state <= ST_NEXTF;
                    end else begin
                        pidx <= pidx - 3'd1;
                        dig <= 4'h0;
                        state <= ST_DIV;
                    end
                end
                ST_NEXTF: begin
                    if (last_field) begin
                        tx_char <= CH_CR;
                        ret_state <= ST_DONE;
                    end else begin
                        field <= field + 4'h1;
                        tx_char <= CH_SPACE;
                        ret_state <= ST_LOAD;
                    end
                    state <= ST_SEND;
                end
                ST_DONE: begin
                    ev_boot <= boot_mode;
                    ev_record <= ~boot_mode;
                    boot_mode <= 1'b0;
                    state <= ST_IDLE;
                end
                ST_SEND: begin
                    if (tx_free) begin
                        tx_go <= 1'b1;
                        state <= ret_state;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> bench/tfr_framer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tfr_framer_chk import tfr_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_irq,
    // serial out
    input wire logic o_txd
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic [14:0] lo_cnt;
    logic [15:0] fr_cnt;
    logic [4:0] mask_q;
    wire logic fr_end = (fr_cnt == 16'(10 * BIT_CYCLES - 4));
    wire logic fr_off = (fr_cnt == 16'h0000) && o_txd;
    wire logic [14:0] next_lo = o_txd ? 15'h0000 : lo_cnt + 15'h0001;
    wire logic [15:0] next_fr = (fr_off || fr_end) ? 16'h0000 : fr_cnt + 16'h0001;
    wire logic [4:0] next_mask = (i_wr && i_addr == REG_MASK) ? i_wdata[4:0] : mask_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lo_cnt <= '0;
            fr_cnt <= '0;
            mask_q <= '0;
        end else begin
            lo_cnt <= next_lo;
            fr_cnt <= next_fr;
            mask_q <= next_mask;
        end
    end
    AST_TXD_RST: assert property ($rose(i_rst_n) |-> o_txd)
        else $error("serial out low at reset release");
    AST_START_HOLD: assert property (fr_cnt == 16'(BIT_CYCLES / 2) |-> !o_txd)
        else $error("start bit not held");
    AST_STOP_HIGH: assert property (fr_cnt == 16'(9 * BIT_CYCLES + BIT_CYCLES / 2) |-> o_txd)
        else $error("stop bit missing");
    AST_LOW_RUN: assert property ($rose(o_txd) |->
        lo_cnt % 15'(BIT_CYCLES) == 0 && lo_cnt <= 15'(9 * BIT_CYCLES))
        else $error("low run not whole bits");
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_UNMAPPED: assert property (i_rd && i_addr > REG_INFO |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_RB: assert property (i_wr && i_addr == REG_CTRL ##1 i_rd && i_addr == REG_CTRL
        |=> o_rdata[CTRL_VERBOSE] == $past(i_wdata[CTRL_VERBOSE], 2))
        else $error("verbose readback wrong");
    AST_IRQ_MASKED: assert property (mask_q == 5'h00 ##1 mask_q == 5'h00 |-> !o_irq)
        else $error("irq with all masked");
    CVR_FRAME: cover property ($fell(o_txd));
    CVR_IRQ: cover property ($rose(o_irq));
    CVR_CTRL: cover property (i_wr && i_addr == REG_CTRL);
endmodule
`default_nettype wire

// >>> bench/tfr_host.sv
`timescale 1ns/1ps
`default_nettype none
module tfr_host import tfr_pkg::*; (
    // clock and serial lines
    input wire logic i_clk,
    input wire logic i_txd,
    output logic o_rxd
);
    logic [7:0] rx_q[$];
    logic [8:0] sh;
    initial o_rxd = 1'b1;
    // frame given as stop, data, start
    task automatic send(input logic [9:0] f);
        for (int i = 0; i < FRAME_BITS; i++) begin
            o_rxd <= f[i];
            repeat (BIT_CYCLES) @(posedge i_clk);
        end
    endtask
    initial forever begin
        @(negedge i_txd);
        repeat (BIT_CYCLES / 2) @(posedge i_clk);
        for (int i = 0; i < DATA_BITS + 1; i++) begin
            repeat (BIT_CYCLES) @(posedge i_clk);
            sh = {i_txd, sh[8:1]};
        end
        if (sh[8] === 1'b1) rx_q.push_back(sh[7:0]);
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import tfr_pkg::*; ;
    localparam int unsigned RP = 20000;
    logic clk, rst_n, wr, rd, rxd, txd, irq, comp, alarm;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [SPEED_W-1:0] spd1, spd2, setp;
    logic [VAL_W-1:0] trq;
    logic [LOAD_W-1:0] load;
    logic [1:0] mode;
    logic [THR_W-1:0] thr;
    logic [ADC_N*ADC_W-1:0] adc;
    logic [31:0] lf = 32'hFADCD8AC;
    logic [127:0] rnd;
    int error_cnt = 0, n_tests = 0, t;
    tfr_framer #(.REPORT_PERIOD(RP)) i_tfr_framer (.i_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
        .i_rxd(rxd), .o_txd(txd), .i_speed_disp(spd1), .i_speed_hidden(spd2),
        .i_torque_milli(trq), .i_load_pct(load), .i_computer_ctl(comp), .i_loop_mode(mode),
        .i_set_point(setp), .i_throttle(thr), .i_alarm(alarm), .i_analog(adc));
    tfr_host i_tfr_host (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic string rec_exp();
        string m = "MSTR";
        return $sformatf("Z%0d %0d %0d.%03d %0d %s%s %0d %0d %0d %0d %0d %0d %0d\r", spd1,
            spd2, trq / 1000, trq % 1000, load, comp ? "C" : "N", m.substr(mode, mode), setp,
            thr, alarm, adc[9:0], adc[19:10], adc[29:20], adc[39:30]);
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic chk_msg(input string e);
        while (i_tfr_host.rx_q.size() < e.len()) @(posedge clk);
        for (int i = 0; i < e.len(); i++) chk("char", 16'(e[i]), 16'(i_tfr_host.rx_q.pop_front()));
    endtask
    task automatic wrr(input logic [3:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (4_000_000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        #1 rst_n = 1'b0;
        {wr, rd, addr, wdata} = '0;
        {spd1, spd2, trq, setp, load, comp, mode, thr, alarm, adc} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdr(REG_CTRL, d);
        chk("ctrl reset", 16'(CTRL_RST), 16'(d));
        rdr(4'hA, d);
        chk("unmapped", 16'h0000, 16'(d));
        wrr(REG_MASK, 8'h1F);
        chk_msg($sformatf("POWER ON V%0d\r", FW_VERSION_DEF));
        repeat (BIT_CYCLES) @(posedge clk);
        chk("irq set", 16'h0001, 16'(irq));
        rdr(REG_STATUS, d);
        chk("boot event", 16'h0001, 16'(d[EV_BOOT]));
        repeat (2) @(posedge clk);
        chk("irq clear", 16'h0000, 16'(irq));
        {spd1, spd2, trq, setp, load, comp, mode} <= {14'h0000, 14'h3FFF, 16'h000C, 14'h0000,
            7'h64, 1'b1, MODE_ROAD};
        {thr, alarm, adc} <= {10'h3FF, 1'b1, 10'h3FF, 10'h001, 10'h000, 10'h3FF};
        i_tfr_host.send({1'b1, CH_REQ, 1'b0});
        chk_msg(rec_exp());
        repeat (BIT_CYCLES) @(posedge clk);
        chk("one record", 16'h0001, 16'(txd));
        rdr(REG_STATUS, d);
        chk("req events", 16'h0005, 16'(d[4:0]));
        repeat (4) begin
            repeat (32) lf = lfsr(lf);
            rnd = {rnd[95:0], lf};
        end
        {spd1, spd2, trq, setp, load, comp, mode, thr, alarm, adc} <= rnd[118:0];
        wrr(REG_CTRL, 8'h01);
        rdr(REG_CTRL, d);
        chk("verbose", 16'h0001, 16'(d));
        t = 0;
        while (txd === 1'b1) begin
            @(posedge clk);
            t++;
        end
        chk("period", 16'h0001, 16'(t > RP - 8 && t < RP + 8));
        chk_msg(rec_exp());
        @(posedge clk);
        i_tfr_host.send({1'b1, CH_REQ, 1'b0});
        repeat (4) @(posedge clk);
        rdr(REG_STATUS, d);
        chk("ignored", 16'h0001, 16'(d[EV_IGNORED]));
        report_and_stop();
    end
endmodule
bind tfr_framer tfr_framer_chk i_tfr_framer_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_txd(o_txd));
`default_nettype wire
